//--- logic/mcc_pkg.sv
// package: register map, field layout, reset values and counts of the
// main clock controller with time base and beeper.
// assumes hclk is the oscillator clock at 125 MHz.
package mcc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register indices (byte address is four times the index)
  localparam logic [7:0] MCC_CSR_INDEX = 8'h2C;
  localparam logic [7:0] MCC_BEEP_INDEX = 8'h2D;
  localparam logic [9:0] MCC_CSR_ADDR = {MCC_CSR_INDEX, 2'b00};
  localparam logic [9:0] MCC_BEEP_ADDR = {MCC_BEEP_INDEX, 2'b00};

  // control/status field positions
  localparam int MCC_BIT_CLKOUT = 7;
  localparam int MCC_BIT_DIV_HI = 6;
  localparam int MCC_BIT_DIV_LO = 5;
  localparam int MCC_BIT_SLOW = 4;
  localparam int MCC_BIT_TB_HI = 3;
  localparam int MCC_BIT_TB_LO = 2;
  localparam int MCC_BIT_IE = 1;
  localparam int MCC_BIT_FLAG = 0;

  // reset values
  localparam logic [7:0] MCC_CSR_RESET = 8'h00;
  localparam logic [1:0] MCC_BEEP_RESET = 2'h0;

  // time base periods in oscillator cycles
  localparam int MCC_TB_WIDTH = 18;
  localparam int MCC_TB_CYC0 = 16000;
  localparam int MCC_TB_CYC1 = 32000;
  localparam int MCC_TB_CYC2 = 80000;
  localparam int MCC_TB_CYC3 = 200000;

  // beep tones: half period in hclk cycles, rounded down
  localparam int MCC_CLK_HZ = 125000000;
  localparam int MCC_BEEP_HZ1 = 2000;
  localparam int MCC_BEEP_HZ2 = 1000;
  localparam int MCC_BEEP_HZ3 = 500;
  localparam int MCC_BEEP_HALF1 = MCC_CLK_HZ / (2 * MCC_BEEP_HZ1);
  localparam int MCC_BEEP_HALF2 = MCC_CLK_HZ / (2 * MCC_BEEP_HZ2);
  localparam int MCC_BEEP_HALF3 = MCC_CLK_HZ / (2 * MCC_BEEP_HZ3);

  // core clock divider periods
  localparam logic [4:0] MCC_DIV_NORMAL = 5'h01;

  // power states
  typedef enum logic [2:0] {
    MCC_RUN = 3'b001,
    MCC_SLEEP = 3'b010,
    MCC_HALT = 3'b100
  } mcc_state_t;

endpackage

//--- logic/mcc_period_counter.sv
// period counter: ticks once every 'period' enabled cycles.
// a new period is adopted only when the running one ends.
`timescale 1ns/1ps

module mcc_period_counter #(
  parameter int W = 18,
  parameter logic [W-1:0] INIT_PERIOD = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  input wire logic [W-1:0] period,
  output logic tick,
  output logic [W-1:0] count
);

  logic [W-1:0] cur;

  // end of the running period
  assign tick = run && (count == cur - 1'b1);

  ////////////////////////////////////////////////////////////////////////
  // count and swap period only at the boundary, avoids a time shift
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      cur <= INIT_PERIOD;
    end else if (ce && run) begin
      if (tick) begin
        count <= '0;
        cur <= period;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

endmodule // mcc_period_counter

//--- logic/mcc_top.sv
// main clock controller: core clock prescaler, clock-out, time base and
// beeper behind an AHB-Lite slave. hclk is the oscillator clock.
// assumes the core pulses halt_req and wake_irq on hclk.
//
// Overview of operation
// RULE1 - normal mode core clock equals oscillator
// RULE2 - slow divider picks 2, 4, 8, 16
// RULE3 - bit 7 routes oscillator onto clock-out pin
// RULE4 - clock-out suspended during timed sleep
// RULE5 - time base periods 16000 to 200000 cycles
// RULE6 - new time base applies after current period
// RULE7 - period end sets flag; status read clears
// RULE8 - interrupt while flag and enable set
// RULE9 - enable set makes halt enter timed sleep
// RULE10 - wait mode unaffected; interrupt ends wait
// RULE11 - timed sleep keeps counter, freezes registers
// RULE12 - full halt freezes all; only wake input (clock_out_run still follows bit 7, and a status read still clears the flag)
// RULE13 - beeper tone on port pin, three tones
// RULE14 - tone field: off, 2k, 1k, 500 Hz
// RULE15 - software keeps beep upper bits zero
// RULE16 - status register resets to zero
// RULE17 - prescaler, clock-out, time base independent
// RULE18 - software avoids bit set/clear on status
// RULE19 - event wins over simultaneous read clear
// RULE20 - divider changes only on divider boundary
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps

module mcc_top
  import mcc_pkg::*;
#(
  parameter int TB_PERIOD0 = MCC_TB_CYC0,
  parameter int TB_PERIOD1 = MCC_TB_CYC1,
  parameter int TB_PERIOD2 = MCC_TB_CYC2,
  parameter int TB_PERIOD3 = MCC_TB_CYC3,
  parameter int BEEP_HALF1 = MCC_BEEP_HALF1,
  parameter int BEEP_HALF2 = MCC_BEEP_HALF2,
  parameter int BEEP_HALF3 = MCC_BEEP_HALF3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic halt_req,
  input wire logic wake_irq,
  output logic core_clk_en,
  output logic clock_out_sel,
  output logic clock_out_run,
  output logic tone_sel,
  output logic tone_port_pin,
  output logic time_base_irq,
  output logic timed_sleep,
  output logic full_halt
);

  localparam int TW = MCC_TB_WIDTH;

  mcc_state_t state;
  mcc_state_t next_state;
  logic [7:0] csr;
  logic [7:1] csr_ctl;
  logic csr_flag;
  logic [1:0] beep_tone_select;
  logic wr_pend;
  logic [9:0] wr_addr;
  logic addr_take;
  logic csr_read;
  logic reg_wr_ok;
  logic tb_tick;
  logic [TW-1:0] tb_period;
  logic [TW-1:0] tb_count;
  logic [TW-1:0] beep_period;
  logic beep_tick;
  logic [4:0] div_period;
  logic div_tick;
  logic [4:0] div_count;
  logic slow_select;
  logic [1:0] slow_divider_select;
  logic [1:0] time_base_select;
  logic time_base_irq_enable;
  logic time_base_overflow_flag;

  // software half and hardware flag kept in separate flops, one driver each
  assign csr = {csr_ctl, csr_flag};
  assign slow_select = csr[MCC_BIT_SLOW];
  assign slow_divider_select = csr[MCC_BIT_DIV_HI:MCC_BIT_DIV_LO];
  assign time_base_select = csr[MCC_BIT_TB_HI:MCC_BIT_TB_LO];
  assign time_base_irq_enable = csr[MCC_BIT_IE];
  assign time_base_overflow_flag = csr[MCC_BIT_FLAG];

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_take = hsel && htrans[1] && hready && ce;
  assign csr_read = addr_take && !hwrite && (haddr[9:0] == MCC_CSR_ADDR);
  // registers hold still while the core sleeps
  assign reg_wr_ok = wr_pend && ce && (state == MCC_RUN); // see RULE11 see RULE12

  // latch the address phase of a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else if (ce) begin
      wr_pend <= addr_take && hwrite;
      wr_addr <= haddr[9:0];
    end
  end

  // read data captured at the address phase; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (addr_take && !hwrite) begin
      if (haddr[9:0] == MCC_CSR_ADDR) begin
        hrdata <= {24'h000000, csr};
      end else if (haddr[9:0] == MCC_BEEP_ADDR) begin
        hrdata <= {30'h0000000, beep_tone_select}; // upper bits read zero, see RULE15
      end else begin
        hrdata <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control bits 7:1 written by software, flag is hardware owned
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csr_ctl <= MCC_CSR_RESET[7:1]; // see RULE16
    end else if (reg_wr_ok && wr_addr == MCC_CSR_ADDR) begin
      csr_ctl <= hwdata[7:1];
    end
  end

  // overflow flag: the period end beats a clearing read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csr_flag <= MCC_CSR_RESET[MCC_BIT_FLAG]; // see RULE16
    end else if (ce) begin
      if (tb_tick) begin
        csr_flag <= 1'b1; // see RULE7 see RULE19
      end else if (csr_read) begin
        csr_flag <= 1'b0; // see RULE7
      end
    end
  end

  // beep control: only the tone field is stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      beep_tone_select <= MCC_BEEP_RESET; // see RULE15
    end else if (reg_wr_ok && wr_addr == MCC_BEEP_ADDR) begin
      beep_tone_select <= hwdata[1:0]; // see RULE13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power state: halt goes to timed sleep if the interrupt is enabled
  always_comb begin
    next_state = state;
    case (state)
      MCC_RUN: begin
        if (halt_req) begin
          next_state = time_base_irq_enable ? MCC_SLEEP : MCC_HALT; // see RULE9
        end
      end
      MCC_SLEEP: begin
        if (time_base_irq || wake_irq) begin
          next_state = MCC_RUN; // see RULE11
        end
      end
      MCC_HALT: begin
        if (wake_irq) begin
          next_state = MCC_RUN; // see RULE12
        end
      end
      default: begin
        next_state = MCC_RUN;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= MCC_RUN;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign timed_sleep = (state == MCC_SLEEP);
  assign full_halt = (state == MCC_HALT);
  // wait mode is the core's own affair; this request also ends it
  assign time_base_irq = time_base_overflow_flag && time_base_irq_enable; // see RULE8 see RULE10

  ////////////////////////////////////////////////////////////////////////
  // core clock prescaler; period 1 means every oscillator cycle
  always_comb begin
    if (!slow_select) begin
      div_period = MCC_DIV_NORMAL; // see RULE1
    end else begin
      div_period = 5'(5'h02 << slow_divider_select); // see RULE2
    end
  end

  // the divider adopts a new ratio only when its period ends
  mcc_period_counter #(.W(5), .INIT_PERIOD(MCC_DIV_NORMAL)) u_core_div (
    .clk(hclk), .rst_n(hresetn), .ce(ce), .run(state == MCC_RUN),
    .period(div_period), .tick(div_tick), .count(div_count)
  ); // see RULE20

  // core clock enable stops while the core sleeps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_clk_en <= 1'b0;
    end else if (ce) begin
      core_clk_en <= div_tick && (next_state == MCC_RUN); // see RULE1 see RULE17
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock-out pin: select and gate; the pad muxes the oscillator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_out_sel <= 1'b0;
      clock_out_run <= 1'b0;
    end else if (ce) begin
      clock_out_sel <= (reg_wr_ok && wr_addr == MCC_CSR_ADDR) ?
        hwdata[MCC_BIT_CLKOUT] : csr[MCC_BIT_CLKOUT]; // see RULE3
      clock_out_run <= csr[MCC_BIT_CLKOUT] && (next_state != MCC_SLEEP); // see RULE4
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // time base: runs in run and timed sleep, frozen in full halt
  always_comb begin
    case (time_base_select)
      2'h0: tb_period = TW'(TB_PERIOD0); // see RULE5
      2'h1: tb_period = TW'(TB_PERIOD1);
      2'h2: tb_period = TW'(TB_PERIOD2);
      default: tb_period = TW'(TB_PERIOD3);
    endcase
  end

  mcc_period_counter #(.W(TW), .INIT_PERIOD(TW'(TB_PERIOD0))) u_time_base (
    .clk(hclk), .rst_n(hresetn), .ce(ce), .run(state != MCC_HALT),
    .period(tb_period), .tick(tb_tick), .count(tb_count)
  ); // see RULE6 see RULE12

  ////////////////////////////////////////////////////////////////////////
  // beeper: half-period toggle gives about half duty
  always_comb begin
    case (beep_tone_select)
      2'h1: beep_period = TW'(BEEP_HALF1); // see RULE14
      2'h2: beep_period = TW'(BEEP_HALF2);
      default: beep_period = TW'(BEEP_HALF3);
    endcase
  end

  mcc_period_counter #(.W(TW), .INIT_PERIOD(TW'(BEEP_HALF3))) u_beep (
    .clk(hclk), .rst_n(hresetn), .ce(ce),
    .run((beep_tone_select != 2'h0) && (state != MCC_HALT)),
    .period(beep_period), .tick(beep_tick), .count()
  );

  // tone output low while off; stays available in timed sleep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tone_sel <= 1'b0;
      tone_port_pin <= 1'b0;
    end else if (ce) begin
      tone_sel <= (beep_tone_select != 2'h0); // see RULE13
      if (beep_tone_select == 2'h0) begin
        tone_port_pin <= 1'b0;
      end else if (beep_tick) begin
        tone_port_pin <= !tone_port_pin; // see RULE14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // an enabled core clock pulse, and the idle cycle that must follow at ratio 2
  sequence s_div_hi;
    core_clk_en && ce;
  endsequence
  sequence s_div_lo;
    !core_clk_en;
  endsequence
  property p_flag_set;
    ce && tb_tick |=> time_base_overflow_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set at period end"); // see RULE19
  property p_read_clear;
    ce && csr_read && !tb_tick |=> !time_base_overflow_flag;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear flag"); // see RULE7
  property p_irq;
    ce && tb_tick && time_base_irq_enable && !reg_wr_ok |=> time_base_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled period end gave no irq"); // see RULE8
  property p_sleep_entry;
    ce && state == MCC_RUN && halt_req && time_base_irq_enable |=> timed_sleep && !full_halt;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("halt missed timed sleep"); // see RULE9
  property p_halt_hold;
    ce && full_halt && !wake_irq |=> full_halt && $stable(tb_count) && $stable(csr);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("full halt not frozen"); // see RULE12
  property p_sleep_wake;
    ce && timed_sleep && time_base_irq |=> state == MCC_RUN;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("irq did not wake"); // see RULE11
  property p_clkout_sleep;
    timed_sleep |-> !clock_out_run;
  endproperty
  a_clkout_sleep: assert property (p_clkout_sleep) else $error("clock out in sleep"); // see RULE4
  property p_slow_gap;
    s_div_hi ##0 (u_core_div.cur == 5'h02) |=> s_div_lo;
  endproperty
  a_slow_gap: assert property (p_slow_gap) else $error("slow divider gap wrong"); // see RULE2
  // a new ratio may only be adopted where a divider period ends
  property p_div_boundary;
    !div_tick |=> $stable(u_core_div.cur);
  endproperty
  a_div_boundary: assert property (p_div_boundary) else $error("early ratio change"); // see RULE20
  property p_normal_clk;
    ce && state == MCC_RUN && u_core_div.cur == MCC_DIV_NORMAL && next_state == MCC_RUN
      |=> core_clk_en;
  endproperty
  a_normal_clk: assert property (p_normal_clk) else $error("normal clock missing"); // see RULE1
endmodule // mcc_top

//--- tb/mcc_core_model.sv
// core model: turns bench commands into halt and wake pulses, counts
// core clock enables. assumes one clock, hclk, shared with the block.
`timescale 1ns/1ps

module mcc_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic halt_cmd,
  input wire logic wake_cmd,
  input wire logic core_clk_en,
  output logic halt_req,
  output logic wake_irq,
  output logic [15:0] core_ticks
);
  ////////////////////////////////////////
  // halt instruction and halt-exit interrupt, one cycle each
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_req <= 1'b0;
      wake_irq <= 1'b0;
    end else begin
      halt_req <= halt_cmd;
      wake_irq <= wake_cmd;
    end
  end

  // core clock count; the bench reads differences, so wrap is harmless
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_ticks <= 16'h0000;
    end else begin
      core_ticks <= core_ticks + {15'h0000, core_clk_en};
    end
  end
endmodule // mcc_core_model

//--- tb/mcc_top_tb.sv
// testbench: bus tasks and directed tests of the clock controller.
// assumes mcc_top and mcc_core_model are compiled before it.
`timescale 1ns/1ps

module mcc_top_tb;
  import mcc_pkg::*;
  localparam int P[4] = '{16, 32, 80, 200};
  localparam int H[4] = '{0, 4, 8, 16};
  logic hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0;
  logic halt_cmd = 0, wake_cmd = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = '0;
  logic hreadyout, hresp, halt_req, wake_irq, core_clk_en, clock_out_sel, clock_out_run;
  logic tone_sel, tone_port_pin, time_base_irq, timed_sleep, full_halt;
  logic [15:0] core_ticks;
  int n_mismatch = 0, checks = 0, cyc = 0, a, b, c, n, old;

  always #4 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  ////////////////////////////////////////
  // short periods keep the run brief
  mcc_top #(.TB_PERIOD0(P[0]), .TB_PERIOD1(P[1]), .TB_PERIOD2(P[2]), .TB_PERIOD3(P[3]),
    .BEEP_HALF1(H[1]), .BEEP_HALF2(H[2]), .BEEP_HALF3(H[3])) i_mcc_top (.hclk, .hresetn, .ce,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .halt_req, .wake_irq, .core_clk_en, .clock_out_sel,
    .clock_out_run, .tone_sel, .tone_port_pin, .time_base_irq, .timed_sleep, .full_halt);
  mcc_core_model i_mcc_core_model (.hclk, .hresetn, .halt_cmd, .wake_cmd, .core_clk_en,
    .halt_req, .wake_irq, .core_ticks);

  ////////////////////////////////////////
  // one single word transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [9:0] ad, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= {22'h0, ad};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // waits for the time base request, stamps it, then clears the flag
  task automatic next_tick(output int at);
    n = 0;
    while (time_base_irq !== 1'b1 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    at = cyc;
    bus(0, MCC_CSR_ADDR, 0, rd);
    chk("flag", rd & 32'h1, 32'h1);
  endtask

  // core clock enables over 64 cycles, a multiple of every ratio
  task automatic meas_core(output int d);
    a = core_ticks;
    repeat (64) @(posedge hclk);
    d = 16'(core_ticks - 16'(a));
  endtask

  task automatic tone_half(output int d);
    logic p;
    n = 0;
    p = tone_port_pin;
    while (tone_port_pin === p && n < 100) begin
      @(posedge hclk);
      n++;
    end
    p = tone_port_pin;
    d = 0;
    while (tone_port_pin === p && d < 100) begin
      @(posedge hclk);
      d++;
    end
  endtask

  task automatic pulse(input logic h);
    @(posedge hclk);
    if (h) halt_cmd <= 1;
    else wake_cmd <= 1;
    @(posedge hclk);
    halt_cmd <= 0;
    wake_cmd <= 0;
    repeat (2) @(posedge hclk);
  endtask

  ////////////////////////////////////////
  // hang guard, well beyond the expected few thousand cycles
  initial begin
    repeat (30000) @(posedge hclk);
    n_mismatch++;
    wrap_up;
  end

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    bus(0, MCC_CSR_ADDR, 0, rd);
    chk("csr reset", rd, {24'h000000, MCC_CSR_RESET});
    chk("hresp", hresp, 1'b0);
    bus(0, MCC_BEEP_ADDR, 0, rd);
    chk("beep reset", rd, 32'h0);
    chk("clkout off", clock_out_sel, 1'b0);
    bus(1, 10'h3F0, 32'hFF, rd);
    bus(0, 10'h3F0, 0, rd);
    chk("unmapped", rd, 32'h0);
    meas_core(n);
    chk("normal clock", n, 64);
    for (int k = 0; k < 4; k++) begin
      bus(1, MCC_CSR_ADDR, 32'h10 | (k << 5), rd);
      repeat (20) @(posedge hclk);
      meas_core(n);
      chk("slow clock", n, 64 >> (k + 1));
    end
    // clock-out, slowest core clock and interrupt enable all at once
    bus(1, MCC_CSR_ADDR, 32'hF2, rd); // whole-word write
    repeat (2) @(posedge hclk);
    chk("clkout on", clock_out_sel, 1'b1);
    next_tick(a);
    old = 0;
    for (int j = 1; j < 5; j++) begin
      next_tick(a);
      bus(1, MCC_CSR_ADDR, 32'hF2 | ((j % 4) << 2), rd);
      next_tick(b);
      next_tick(c);
      chk("old period", b - a, P[old]);
      chk("new period", c - b, P[j % 4]);
      old = j % 4;
    end
    meas_core(n);
    chk("parallel", n, 4);
    bus(0, MCC_CSR_ADDR, 0, rd);
    chk("csr fields", rd & 32'hFE, 32'hF2);
    // flag without enable gives no request
    bus(1, MCC_CSR_ADDR, 32'hF0, rd);
    repeat (40) @(posedge hclk);
    chk("masked irq", time_base_irq, 1'b0);
    bus(0, MCC_CSR_ADDR, 0, rd);
    chk("flag kept", rd & 32'h1, 32'h1);
    // timed sleep, woken by the time base
    bus(1, MCC_CSR_ADDR, 32'h82, rd);
    next_tick(a);
    pulse(1);
    chk("sleep", {timed_sleep, full_halt, clock_out_run}, 3'b100);
    bus(1, MCC_CSR_ADDR, 32'h00, rd);
    n = 0;
    while (timed_sleep !== 1'b0 && n < 40) begin
      @(posedge hclk);
      n++;
    end
    chk("sleep wake", n < 40, 1'b1);
    repeat (2) @(posedge hclk);
    chk("clkout back", clock_out_run, 1'b1);
    bus(0, MCC_CSR_ADDR, 0, rd);
    chk("sleep frozen", rd & 32'hFE, 32'h82);
    // full halt ignores the time base, leaves on wake
    bus(1, MCC_CSR_ADDR, 32'h80, rd);
    pulse(1);
    chk("halt", {full_halt, timed_sleep}, 2'b10);
    repeat (60) @(posedge hclk);
    chk("halt held", {full_halt, time_base_irq}, 2'b10);
    // a running time base would have raised the flag within 60 cycles
    bus(0, MCC_CSR_ADDR, 0, rd);
    chk("halt no flag", rd, 32'h80);
    pulse(0);
    chk("halt wake", full_halt, 1'b0);
    bus(0, MCC_CSR_ADDR, 0, rd);
    chk("halt frozen", rd & 32'hFE, 32'h80);
    // every tone, upper beep bits kept zero
    for (int k = 1; k < 4; k++) begin
      bus(1, MCC_BEEP_ADDR, k, rd);
      repeat (2) @(posedge hclk);
      chk("tone on", tone_sel, 1'b1);
      tone_half(n);
      chk("tone half", n, H[k]);
      bus(0, MCC_BEEP_ADDR, 0, rd);
      chk("beep read", rd, k);
    end
    // clock enable low: the tone must not move at all
    ce <= 1'b0;
    @(posedge hclk);
    old = tone_port_pin;
    n = 0;
    repeat (40) begin
      @(posedge hclk);
      if (tone_port_pin !== old) n++;
    end
    ce <= 1'b1;
    chk("ce freeze", n, 0);
    bus(1, MCC_BEEP_ADDR, 0, rd);
    repeat (2) @(posedge hclk);
    chk("tone off", tone_sel, 1'b0);
    wrap_up;
  end
endmodule // mcc_top_tb
